// file: vic_pkg.sv
// Purpose: Shared constants for the vectored interrupt controller.
// Assumes: APB with 32-bit data, one register per aligned word.
// Notes:   Offsets are byte addresses.
package vic_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL_PRI  = 8'h00;
  localparam logic [7:0] OFF_CTRL_SEC  = 8'h04;
  localparam logic [7:0] OFF_MS_LOW    = 8'h08;
  localparam logic [7:0] OFF_MS_HIGH   = 8'h0c;
  localparam logic [7:0] OFF_EDGE_SEL  = 8'h10;
  localparam logic [7:0] OFF_STATUS    = 8'h14;

  localparam logic [7:0] RST_VAL       = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  // Primary control
  localparam int B_GIE   = 0;
  localparam int B_EN0   = 1;
  localparam int B_EN1   = 2;
  localparam int B_ENT0  = 3;
  localparam int B_F0    = 4;
  localparam int B_F1    = 5;
  localparam int B_FT0   = 6;
  // Secondary control
  localparam int B_ENT1  = 0;
  localparam int B_ENSI  = 1;
  localparam int B_ENMS  = 2;
  localparam int B_FT1   = 4;
  localparam int B_FSI   = 5;
  localparam int B_FMS   = 6;
  // Multi-source low
  localparam int B_ENCV  = 0;
  localparam int B_ENTB0 = 1;
  localparam int B_ENTB1 = 2;
  localparam int B_ENPP  = 3;
  localparam int B_FCV   = 4;
  localparam int B_FTB0  = 5;
  localparam int B_FTB1  = 6;
  localparam int B_FPP   = 7;
  // Multi-source high
  localparam int B_ENCM  = 0;
  localparam int B_ENNV  = 1;
  localparam int B_ENLV  = 2;
  localparam int B_FCM   = 4;
  localparam int B_FNV   = 5;
  localparam int B_FLV   = 6;
  // Edge select
  localparam int B_ES0   = 0;
  localparam int B_ES1   = 2;

  localparam logic [7:0] MASK_PRI  = 8'h7f;
  localparam logic [7:0] MASK_SEC  = 8'h77;
  localparam logic [7:0] MASK_MSL  = 8'hff;
  localparam logic [7:0] MASK_MSH  = 8'h77;
  localparam logic [7:0] MASK_EDGE = 8'h0f;

  // ----------------------------------------------------------------
  // Edge modes and vectors
  // ----------------------------------------------------------------
  localparam logic [1:0] EDGE_OFF  = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  localparam logic [7:0] VEC_EXT0  = 8'h04;
  localparam logic [7:0] VEC_EXT1  = 8'h08;
  localparam logic [7:0] VEC_TMR0  = 8'h0c;
  localparam logic [7:0] VEC_TMR1  = 8'h10;
  localparam logic [7:0] VEC_SER   = 8'h14;
  localparam logic [7:0] VEC_MULTI = 8'h18;

  localparam int NUM_SRC = 6;

  typedef enum logic [1:0] {
    VIC_IDLE = 2'b00,
    VIC_GRANT = 2'b01,
    VIC_WAIT = 2'b10
  } vic_state_t;

endpackage : vic_pkg

// file: vic_edge_detect.sv
// Purpose: Filtered edge detector for one external request pin.
// Assumes: Pin synchronous to clock.
// Notes:   Filter needs two equal samples before a level is accepted.
`timescale 1ns/100ps
module vic_edge_detect (
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       pinIn,
  input  wire logic       filterOn,
  input  wire logic [1:0] edgeSel,
  output logic            hit
);

  logic prevSample_r;
  logic level_r;
  logic levelOld_r;
  logic levelNxt;
  logic rise;
  logic fall;

  // One shared filter option for both external edge pins; off trades noise for power
  assign levelNxt = filterOn ? ((pinIn == prevSample_r) ? pinIn : level_r) : pinIn;
  assign rise     = level_r & ~levelOld_r;
  assign fall     = ~level_r & levelOld_r;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      prevSample_r <= 1'b0;
      level_r      <= 1'b0;
      levelOld_r   <= 1'b0;
    end else begin
      prevSample_r <= pinIn;
      level_r      <= levelNxt;
      levelOld_r   <= level_r;
    end
  end

  // Mode decode
  assign hit = ((edgeSel == vic_pkg::EDGE_RISE) & rise) |
               ((edgeSel == vic_pkg::EDGE_FALL) & fall) |
               ((edgeSel == vic_pkg::EDGE_BOTH) & (rise | fall));

endmodule : vic_edge_detect

// file: vic_arbiter.sv
// Purpose: Fixed-priority pick among pending enabled sources.
// Assumes: Bit 0 is the highest priority.
// Notes:   Purely combinational.
`timescale 1ns/100ps
module vic_arbiter #(
  parameter int N = 6
) (
  input  wire logic [N-1:0] req,
  output logic      [N-1:0] grant,
  output logic              any
);

  function automatic logic [N-1:0] lowestOne(input logic [N-1:0] v);
    logic [N-1:0] r;
    r = v & (~v + {{(N-1){1'b0}}, 1'b1});
    return r;
  endfunction : lowestOne

  assign grant = lowestOne(req);
  assign any   = |req;

endmodule : vic_arbiter

// file: vic_controller.sv
// Purpose: Vectored interrupt controller with APB register access.
// Assumes: Core gives phase_two_pulse once per instruction cycle.
// Notes:   Sources deliver one-cycle event pulses.
//          A register write lands once, at the edge that ends its access.
`timescale 1ns/100ps
module vic_controller (
  input  wire logic        clock,
  input  wire logic        rstn,
  // APB
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Pins and options
  input  wire logic        ext_pin_zero,
  input  wire logic        ext_pin_one,
  input  wire logic        pinZeroIsInput,
  input  wire logic        pinOneIsInput,
  input  wire logic        periph_irq_pin_n,
  input  wire logic        periphPinSelect,
  input  wire logic        filterOn,
  output logic             timerInFilterOn,
  // Source events
  input  wire logic        timerZeroOvf,
  input  wire logic        timerOneOvf,
  input  wire logic        serialDone,
  input  wire logic        conversionDone,
  input  wire logic        timebaseZeroTick,
  input  wire logic        timebaseOneTick,
  input  wire logic        comparatorChange,
  input  wire logic        nvmCycleDone,
  input  wire logic        lowVoltageEvent,
  // Core sequencer
  input  wire logic        phase_two_pulse,
  input  wire logic        stackFull,
  input  wire logic        return_from_irq_instr,
  output logic             irqCall,
  output logic      [7:0]  irqVector,
  output logic             pushNextPc,
  output logic             popPc
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0] ctrlPri_r;
  logic [7:0] ctrlSec_r;
  logic [7:0] msLow_r;
  logic [7:0] msHigh_r;
  logic [7:0] edgeSel_r;
  logic [7:0] ctrlPri_nxt;
  logic [7:0] ctrlSec_nxt;
  logic [7:0] msLow_nxt;
  logic [7:0] msHigh_nxt;
  logic [7:0] edgeSel_nxt;
  logic       periphSample_r;
  logic       ack_r;
  logic [5:0] ackGrant_r;
  vic_pkg::vic_state_t state_r;
  vic_pkg::vic_state_t state_nxt;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic       wrEn;
  logic       rdEn;
  logic       selPri;
  logic       selSec;
  logic       selMsl;
  logic       selMsh;
  logic       selEdge;
  logic       selStat;
  logic       mapped;
  logic       accessDone;
  logic [7:0] statusByte;
  logic [7:0] rdByte;

  // Land writes once, where pready is seen; a second landing could wipe a fresh flag
  assign accessDone = psel & penable & pready;
  assign wrEn    = accessDone & pwrite;
  assign rdEn    = psel & penable & ~pwrite;
  assign selPri  = (paddr == vic_pkg::OFF_CTRL_PRI);
  assign selSec  = (paddr == vic_pkg::OFF_CTRL_SEC);
  assign selMsl  = (paddr == vic_pkg::OFF_MS_LOW);
  assign selMsh  = (paddr == vic_pkg::OFF_MS_HIGH);
  assign selEdge = (paddr == vic_pkg::OFF_EDGE_SEL);
  assign selStat = (paddr == vic_pkg::OFF_STATUS);
  assign mapped  = selPri | selSec | selMsl | selMsh | selEdge | selStat;

  // Status lets software see a call held back by a full stack
  assign statusByte = {5'h00, stackFull, state_r};

  // Masks keep unimplemented bits at zero on read
  assign rdByte = selPri  ? (ctrlPri_r & vic_pkg::MASK_PRI) :
                  selSec  ? (ctrlSec_r & vic_pkg::MASK_SEC) :
                  selMsl  ? (msLow_r & vic_pkg::MASK_MSL) :
                  selMsh  ? (msHigh_r & vic_pkg::MASK_MSH) :
                  selEdge ? (edgeSel_r & vic_pkg::MASK_EDGE) :
                  selStat ? statusByte : 8'h00;

  // ----------------------------------------------------------------
  // Source event detection
  // ----------------------------------------------------------------
  logic hit0;
  logic hit1;
  logic pinZeroLive;
  logic pinOneLive;
  logic periphFall;

  // Pin is gated off unless enabled and set as an input
  assign pinZeroLive = ext_pin_zero & ctrlPri_r[vic_pkg::B_EN0] & pinZeroIsInput;
  assign pinOneLive  = ext_pin_one & ctrlPri_r[vic_pkg::B_EN1] & pinOneIsInput;

  vic_edge_detect u_edge0 (
    .clock    (clock),
    .rstn     (rstn),
    .pinIn    (pinZeroLive),
    .filterOn (filterOn),
    .edgeSel  (edgeSel_r[vic_pkg::B_ES0 +: 2]),
    .hit      (hit0)
  );

  vic_edge_detect u_edge1 (
    .clock    (clock),
    .rstn     (rstn),
    .pinIn    (pinOneLive),
    .filterOn (filterOn),
    .edgeSel  (edgeSel_r[vic_pkg::B_ES1 +: 2]),
    .hit      (hit1)
  );

  assign periphFall = periphPinSelect & periphSample_r & ~periph_irq_pin_n;

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  logic [5:0] pending;
  logic [5:0] grant;
  logic       anyPending;
  logic       sampleNow;
  logic [7:0] vecSel;

  assign pending[0] = ctrlPri_r[vic_pkg::B_F0] & ctrlPri_r[vic_pkg::B_EN0];
  assign pending[1] = ctrlPri_r[vic_pkg::B_F1] & ctrlPri_r[vic_pkg::B_EN1];
  assign pending[2] = ctrlPri_r[vic_pkg::B_FT0] & ctrlPri_r[vic_pkg::B_ENT0];
  assign pending[3] = ctrlSec_r[vic_pkg::B_FT1] & ctrlSec_r[vic_pkg::B_ENT1];
  assign pending[4] = ctrlSec_r[vic_pkg::B_FSI] & ctrlSec_r[vic_pkg::B_ENSI];
  assign pending[5] = ctrlSec_r[vic_pkg::B_FMS] & ctrlSec_r[vic_pkg::B_ENMS];

  vic_arbiter #(
    .N (vic_pkg::NUM_SRC)
  ) u_arb (
    .req   (pending),
    .grant (grant),
    .any   (anyPending)
  );

  // Sample only at phase two; a full stack defers the grant
  assign sampleNow = (state_r == vic_pkg::VIC_IDLE) & phase_two_pulse &
                     ctrlPri_r[vic_pkg::B_GIE] & ~stackFull & anyPending;

  assign vecSel = grant[0] ? vic_pkg::VEC_EXT0 :
                  grant[1] ? vic_pkg::VEC_EXT1 :
                  grant[2] ? vic_pkg::VEC_TMR0 :
                  grant[3] ? vic_pkg::VEC_TMR1 :
                  grant[4] ? vic_pkg::VEC_SER : vic_pkg::VEC_MULTI;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      vic_pkg::VIC_IDLE:  if (sampleNow) state_nxt = vic_pkg::VIC_GRANT;
      vic_pkg::VIC_GRANT: state_nxt = vic_pkg::VIC_WAIT;
      vic_pkg::VIC_WAIT:  if (phase_two_pulse) state_nxt = vic_pkg::VIC_IDLE;
      default:            state_nxt = vic_pkg::VIC_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Flag and control next values; hardware set wins over any clear
  // ----------------------------------------------------------------
  logic [7:0] setPri;
  logic [7:0] setSec;
  logic [7:0] setMsl;
  logic [7:0] setMsh;
  logic [7:0] clrPri;
  logic [7:0] clrSec;
  logic       msEvent;

  // Flags record even with global enable clear
  assign setPri = ({7'h00, 1'b0} |
                   ({7'h00, hit0} << vic_pkg::B_F0) |
                   ({7'h00, hit1} << vic_pkg::B_F1) |
                   ({7'h00, timerZeroOvf} << vic_pkg::B_FT0));
  assign setMsl = ({7'h00, conversionDone} << vic_pkg::B_FCV) |
                  ({7'h00, timebaseZeroTick} << vic_pkg::B_FTB0) |
                  ({7'h00, timebaseOneTick} << vic_pkg::B_FTB1) |
                  ({7'h00, periphFall} << vic_pkg::B_FPP);
  assign setMsh = ({7'h00, comparatorChange} << vic_pkg::B_FCM) |
                  ({7'h00, nvmCycleDone} << vic_pkg::B_FNV) |
                  ({7'h00, lowVoltageEvent} << vic_pkg::B_FLV);
  // Only enabled members raise the shared flag
  assign msEvent = |(setMsl[7:4] & {msLow_r[vic_pkg::B_ENPP], msLow_r[vic_pkg::B_ENTB1],
                                     msLow_r[vic_pkg::B_ENTB0], msLow_r[vic_pkg::B_ENCV]})
                 | |(setMsh[6:4] & msHigh_r[2:0]);
  assign setSec = ({7'h00, timerOneOvf} << vic_pkg::B_FT1) |
                  ({7'h00, serialDone} << vic_pkg::B_FSI) |
                  ({7'h00, msEvent} << vic_pkg::B_FMS);

  // Service clears granted flag and global enable; multi leaves members
  assign clrPri = ack_r ? (({7'h00, 1'b1} << vic_pkg::B_GIE) |
                           ({7'h00, ackGrant_r[0]} << vic_pkg::B_F0) |
                           ({7'h00, ackGrant_r[1]} << vic_pkg::B_F1) |
                           ({7'h00, ackGrant_r[2]} << vic_pkg::B_FT0)) : 8'h00;
  assign clrSec = ack_r ? (({7'h00, ackGrant_r[3]} << vic_pkg::B_FT1) |
                           ({7'h00, ackGrant_r[4]} << vic_pkg::B_FSI) |
                           ({7'h00, ackGrant_r[5]} << vic_pkg::B_FMS)) : 8'h00;

  function automatic logic [7:0] regNext(input logic [7:0] cur, input logic wr,
                                         input logic [7:0] wdata, input logic [7:0] clr,
                                         input logic [7:0] set, input logic [7:0] mask);
    logic [7:0] v;
    v = wr ? wdata : (cur & ~clr);
    return (v | set) & mask;
  endfunction : regNext

  assign ctrlPri_nxt = regNext(ctrlPri_r, wrEn & selPri, pwdata[7:0], clrPri, setPri,
                               vic_pkg::MASK_PRI);
  assign ctrlSec_nxt = regNext(ctrlSec_r, wrEn & selSec, pwdata[7:0], clrSec, setSec,
                               vic_pkg::MASK_SEC);
  // Member flags never cleared by hardware
  assign msLow_nxt   = regNext(msLow_r, wrEn & selMsl, pwdata[7:0], 8'h00, setMsl,
                               vic_pkg::MASK_MSL);
  assign msHigh_nxt  = regNext(msHigh_r, wrEn & selMsh, pwdata[7:0], 8'h00, setMsh,
                               vic_pkg::MASK_MSH);
  assign edgeSel_nxt = regNext(edgeSel_r, wrEn & selEdge, pwdata[7:0], 8'h00, 8'h00,
                               vic_pkg::MASK_EDGE);

  // ----------------------------------------------------------------
  // Sequential state
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ctrlPri_r <= vic_pkg::RST_VAL;
      ctrlSec_r <= vic_pkg::RST_VAL;
      msLow_r   <= vic_pkg::RST_VAL;
      msHigh_r  <= vic_pkg::RST_VAL;
      edgeSel_r <= vic_pkg::RST_VAL;
    end else begin
      ctrlPri_r <= ctrlPri_nxt;
      ctrlSec_r <= ctrlSec_nxt;
      msLow_r   <= msLow_nxt;
      msHigh_r  <= msHigh_nxt;
      edgeSel_r <= edgeSel_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_r        <= vic_pkg::VIC_IDLE;
      ack_r          <= 1'b0;
      ackGrant_r     <= 6'h00;
      periphSample_r <= 1'b1;
    end else begin
      state_r        <= state_nxt;
      ack_r          <= sampleNow;
      ackGrant_r     <= sampleNow ? grant : 6'h00;
      periphSample_r <= periph_irq_pin_n;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  logic [7:0]  irqVector_nxt;
  logic [31:0] prdata_nxt;
  logic        pready_nxt;
  logic        pslverr_nxt;

  // Vector holds between calls so the core may fetch it late
  assign irqVector_nxt = sampleNow ? vecSel : irqVector;
  // One wait state; data and error stand only while pready is high
  assign pready_nxt    = psel & penable & ~pready;
  assign prdata_nxt    = (rdEn & ~pready) ? {24'h00_0000, rdByte} : 32'h0000_0000;
  assign pslverr_nxt   = pready_nxt & ~mapped;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      irqCall         <= 1'b0;
      irqVector       <= 8'h00;
      pushNextPc      <= 1'b0;
      popPc           <= 1'b0;
      timerInFilterOn <= 1'b0;
    end else begin
      irqCall         <= sampleNow;
      irqVector       <= irqVector_nxt;
      pushNextPc      <= sampleNow;
      popPc           <= return_from_irq_instr;
      timerInFilterOn <= filterOn;
    end
  end

  // ----------------------------------------------------------------
  // APB response
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= prdata_nxt;
      pready  <= pready_nxt;
      pslverr <= pslverr_nxt;
    end
  end

endmodule : vic_controller

// file: vic_asserts.sv
// Purpose: Port-level checks for the interrupt controller.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Bound onto vic_controller below.
`timescale 1ns/100ps
module vic_asserts (
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        phase_two_pulse,
  input wire logic        stackFull,
  input wire logic        return_from_irq_instr,
  input wire logic        irqCall,
  input wire logic [7:0]  irqVector,
  input wire logic        pushNextPc,
  input wire logic        popPc
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  // ------------------------------------------------
  // Sequences
  // ------------------------------------------------
  sequence apbWait; psel && penable && !pready; endsequence
  sequence callPulse; irqCall ##1 !irqCall; endsequence
  // ------------------------------------------------
  // Checks
  // ------------------------------------------------
  chk_apb_one_wait: assert property (apbWait |=> pready)
    else $error("pready not one cycle after access");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  chk_upper_zero: assert property (pready |-> prdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  chk_err_read_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response carries data");
  chk_call_on_pulse: assert property (irqCall |-> $past(phase_two_pulse) && !$past(stackFull))
    else $error("call outside sampling point");
  chk_call_single: assert property (irqCall |-> callPulse)
    else $error("call longer than one cycle");
  chk_push_with_call: assert property (pushNextPc == irqCall)
    else $error("push not paired with call");
  chk_pop_follows: assert property (popPc == ($past(return_from_irq_instr) && $past(rstn)))
    else $error("pop not one cycle after return");
  chk_vector_legal: assert property (irqCall |-> irqVector inside {8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18})
    else $error("illegal vector");
  chk_vector_hold: assert property (!irqCall |-> $stable(irqVector))
    else $error("vector moved without call");
  cover property (irqCall && irqVector == 8'h18);
endmodule : vic_asserts

bind vic_controller vic_asserts u_chk (.clock, .rstn, .psel, .penable, .prdata, .pready,
  .pslverr, .phase_two_pulse, .stackFull, .return_from_irq_instr, .irqCall, .irqVector,
  .pushNextPc, .popPc);

// file: vic_core_model.sv
// Purpose: Core sequencer stand-in driving phase pulse, stack and return.
// Assumes: Fixed instruction cycle of PERIOD clocks.
// Notes:   Stack fullness is commanded by the bench.
`timescale 1ns/100ps
module vic_core_model #(
  parameter int PERIOD    = 4,
  parameter int RET_DELAY = 6
) (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic holdStack,
  input  wire logic irqCall,
  output logic      phase_two_pulse,
  output logic      stackFull,
  output logic      return_from_irq_instr
);
  int cnt_r;
  int retCnt_r;
  always_ff @(posedge clock) begin
    if (!rstn) begin
      cnt_r <= 0;
      retCnt_r <= 0;
      phase_two_pulse <= 1'b0;
      stackFull <= 1'b0;
      return_from_irq_instr <= 1'b0;
    end else begin
      cnt_r <= (cnt_r == PERIOD - 1) ? 0 : cnt_r + 1;
      phase_two_pulse <= (cnt_r == PERIOD - 1);
      stackFull <= holdStack;
      // Routine ends a while after entry, then returns
      retCnt_r <= irqCall ? RET_DELAY : (retCnt_r != 0 ? retCnt_r - 1 : 0);
      return_from_irq_instr <= (retCnt_r == 1);
    end
  end
endmodule : vic_core_model

// file: vectored_interrupt_controller_tb_top.sv
// Purpose: Self-checking bench for the interrupt controller.
// Assumes: APB slave answers with one wait state.
// Notes:   Calls are counted by a monitor so none is missed.
`timescale 1ns/100ps
module vectored_interrupt_controller_tb_top;
  localparam logic [7:0] PR = vic_pkg::OFF_CTRL_PRI;
  localparam logic [7:0] SC = vic_pkg::OFF_CTRL_SEC;
  localparam logic [7:0] ML = vic_pkg::OFF_MS_LOW;
  localparam logic [7:0] MH = vic_pkg::OFF_MS_HIGH;
  localparam logic [7:0] ED = vic_pkg::OFF_EDGE_SEL;
  typedef struct {logic [7:0] pri, sec, off, ms, msExp, vec; logic [8:0] evm;} vic_row_t;
  logic clock = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, lastErr;
  logic [7:0] paddr = 8'h00, irqVector, vecSeen;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, timerInFilterOn, irqCall, pushNextPc, popPc;
  logic pin0 = 0, pin1 = 0, in0 = 1, pinN = 1, filterOn = 0, holdStack = 0, periphSel = 1;
  logic phase_two_pulse, stackFull, return_from_irq_instr;
  logic [8:0] ev = 9'h000;
  int mismatches = 0, tests_run = 0, callCount = 0, expCalls = 0, pushCount = 0, popCount = 0;
  vic_row_t rows[9] = '{'{8'h09, 8'h00, ML, 8'h00, 8'h00, 8'h0c, 9'h001},
    '{8'h01, 8'h01, ML, 8'h00, 8'h00, 8'h10, 9'h002}, '{8'h01, 8'h02, ML, 8'h00, 8'h00, 8'h14, 9'h004},
    '{8'h01, 8'h04, ML, 8'h01, 8'h11, 8'h18, 9'h008}, '{8'h01, 8'h04, ML, 8'h02, 8'h22, 8'h18, 9'h010},
    '{8'h01, 8'h04, ML, 8'h04, 8'h44, 8'h18, 9'h020}, '{8'h01, 8'h04, MH, 8'h01, 8'h11, 8'h18, 9'h040},
    '{8'h01, 8'h04, MH, 8'h02, 8'h22, 8'h18, 9'h080}, '{8'h01, 8'h04, MH, 8'h04, 8'h44, 8'h18, 9'h100}};
  always #12.5 clock = ~clock;
  vic_controller dut (.clock, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .ext_pin_zero(pin0), .ext_pin_one(pin1), .pinZeroIsInput(in0),
    .pinOneIsInput(1'b1), .periph_irq_pin_n(pinN), .periphPinSelect(periphSel), .filterOn,
    .timerInFilterOn, .timerZeroOvf(ev[0]), .timerOneOvf(ev[1]), .serialDone(ev[2]),
    .conversionDone(ev[3]), .timebaseZeroTick(ev[4]), .timebaseOneTick(ev[5]),
    .comparatorChange(ev[6]), .nvmCycleDone(ev[7]), .lowVoltageEvent(ev[8]),
    .phase_two_pulse, .stackFull, .return_from_irq_instr, .irqCall, .irqVector,
    .pushNextPc, .popPc);
  vic_core_model core (.clock, .rstn, .holdStack, .irqCall, .phase_two_pulse, .stackFull,
    .return_from_irq_instr);
  // Registered call pulse may fall inside a bus cycle, so latch it here
  always @(posedge clock) begin
    if (irqCall === 1'b1) begin
      callCount <= callCount + 1;
      vecSeen <= irqVector;
    end
    if (pushNextPc === 1'b1) pushCount <= pushCount + 1;
    if (popPc === 1'b1) popCount <= popCount + 1;
  end
  // ------------------------------------------------
  // Tasks
  // ------------------------------------------------
  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock); psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock); penable <= 1; n = 0;
    do begin @(posedge clock); n++; end while (pready !== 1'b1 && n < 20);
    r = prdata; lastErr = pslverr; psel <= 0; penable <= 0;
    chk(32'(n < 20), 1);
  endtask : apb
  task wr(input logic [7:0] a, input logic [7:0] d); apb(1, a, {24'h0, d}); endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] e); apb(0, a, 0); chk(r, {24'h0, e}); endtask : rd
  task pulse(input logic [8:0] m); @(posedge clock); ev <= m; @(posedge clock); ev <= 0; endtask : pulse
  task waitCall(input logic [7:0] v);
    int n;
    n = 0;
    while (callCount == expCalls && n < 40) begin @(posedge clock); #1; n++; end
    expCalls++;
    chk(32'(callCount), 32'(expCalls));
    chk({24'h0, vecSeen}, {24'h0, v});
  endtask : waitCall
  task noCall; repeat (24) @(posedge clock); #1; chk(32'(callCount), 32'(expCalls)); endtask : noCall
  task tally_and_finish;
    if (mismatches == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  initial begin repeat (20000) @(posedge clock); mismatches++; tally_and_finish; end
  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial begin
    repeat (4) @(posedge clock); rstn <= 1;
    for (int a = 0; a <= 20; a += 4) rd(8'(a), 8'h00);
    apb(0, 8'h20, 0); chk(r, 0); chk(32'(lastErr), 1);
    wr(ED, 8'hff); rd(ED, 8'h0f); wr(SC, 8'h88); rd(SC, 8'h00); wr(ED, 8'h00);
    filterOn <= 1; repeat (3) @(posedge clock); chk(32'(timerInFilterOn), 1);
    foreach (rows[i]) begin
      wr(SC, rows[i].sec); wr(rows[i].off, rows[i].ms); wr(PR, rows[i].pri);
      pulse(rows[i].evm); waitCall(rows[i].vec);
      rd(PR, rows[i].pri & 8'hfe); rd(SC, rows[i].sec);
      rd(rows[i].off, rows[i].msExp); wr(rows[i].off, 8'h00);
    end
    wr(SC, 8'h03); wr(PR, 8'h09); pulse(9'h007); waitCall(8'h0c);
    wr(PR, 8'h09); waitCall(8'h10); wr(PR, 8'h09); waitCall(8'h14);
    wr(PR, 8'h08); pulse(9'h001); noCall; rd(PR, 8'h48);
    wr(PR, 8'h49); waitCall(8'h0c);
    holdStack <= 1; wr(PR, 8'h09); pulse(9'h001); noCall;
    holdStack <= 0; waitCall(8'h0c);
    for (int k = 0; k < 4; k++) begin
      wr(ED, 8'(k)); wr(PR, 8'h02); pin0 <= 1; repeat (8) @(posedge clock);
      rd(PR, 8'h02 | (8'(k & 1) << 4)); wr(PR, 8'h02); pin0 <= 0;
      repeat (8) @(posedge clock); rd(PR, 8'h02 | (8'(k >> 1) << 4));
    end
    in0 <= 0; wr(ED, 8'h03); wr(PR, 8'h03); pin0 <= 1; repeat (8) @(posedge clock);
    pin0 <= 0; noCall; rd(PR, 8'h03); wr(PR, 8'h00); in0 <= 1;
    wr(ED, 8'h01); wr(PR, 8'h03); pin0 <= 1; waitCall(8'h04); rd(PR, 8'h02);
    filterOn <= 0;
    wr(ED, 8'h04); wr(PR, 8'h05); pin1 <= 1; waitCall(8'h08); rd(PR, 8'h04);
    chk(32'(timerInFilterOn), 0);
    periphSel <= 0; pinN <= 0; repeat (4) @(posedge clock); rd(ML, 8'h00);
    pinN <= 1; periphSel <= 1;
    wr(SC, 8'h04); wr(ML, 8'h08); wr(PR, 8'h01); pinN <= 0; waitCall(8'h18);
    rd(ML, 8'h88); rd(SC, 8'h04); wr(ML, 8'h00); pinN <= 1;
    chk(32'(pushCount), 32'(expCalls)); chk(32'(popCount), 32'(expCalls));
    wr(PR, 8'h0f); rstn <= 0; repeat (4) @(posedge clock); rstn <= 1; rd(PR, 8'h00);
    tally_and_finish;
  end
endmodule : vectored_interrupt_controller_tb_top
